// ---- hw/led_latch_pkg.sv ----
package led_latch_pkg;

  // shift register and latch geometry
  localparam int          SHIFT_W    = 8;
  localparam int          OUT_BIT    = 7;
  localparam int          FAULT_HI   = 6;
  localparam int          FAULT_LO   = 5;
  localparam int          IN_BIT     = 0;

  // event word carried through the buffer: {shift, data, load rise, load fall}
  localparam int          EV_W       = 4;
  localparam int          EV_SHIFT   = 3;
  localparam int          EV_DATA    = 2;
  localparam int          EV_RISE    = 1;
  localparam int          EV_FALL    = 0;
  localparam int          BUF_DEPTH  = 32;

  // open-load sense settles after the latch takes new data
  localparam int          CLK_NS     = 8;
  localparam int          SETTLE_NS  = 100;
  localparam int          SETTLE_W   = 4;
  localparam logic [3:0]  SETTLE_CYC = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  SETTLE_ONE = 4'h1;
  localparam logic [3:0]  SETTLE_IDLE = 4'h0;

  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

endpackage

// ---- hw/serial_led_shift_latch.sv ----
`timescale 1ns/1ps

module event_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic        push;
  logic        pop;

  assign in_ready_o  = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.count != '0);
  assign out_data_o  = st_r.mem[st_r.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data_i;
      st_nxt.wr = (st_r.wr == AW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = (st_r.rd == AW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    st_r.count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");

  fifo_ptr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_r.count == '0 || st_r.count == (AW+1)'(DEPTH)) |-> st_r.wr == st_r.rd)
    else $error("fifo pointers disagree with count");

  // data stands at the output in the cycle after a push into an empty buffer
  fifo_order_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    push && st_r.count == '0 |=> out_valid_o && out_data_o == $past(in_data_i))
    else $error("fifo lost the first word");

endmodule // event_fifo

// Overview of operation
// - each serial clock rising edge shifts the data input into the 8-bit register
// - words go most significant first, D7 on the first clock, D0 on eighth
// - while latch load is high the latch follows the shift register continuously
// - latch load falling edge captures the register; latch holds while load low
// - latch load rising edge overwrites register bits D6 and D5 with fault status
// - fault status leaves on serial output during the next word, no read command
// - serial output shows the last stage, updated on each serial clock rising edge
// - serial output feeds the next device, forming one longer chain
// - blanking high forces all eight sinks off, latch left unchanged
// - blanking low lets each sink follow its latch bit
// - reset clears shift register and latch, all sinks start off
// - after reset the serial output starts low
// - both fault bits set if any enabled output is open, else cleared; others kept
// - after load rise output shows D7, then D6, D5, then D4 to D0
// - shifting and latching ignore blanking; blanking acts on sinks and gates the fault status
// - a bit on the input appears on the output eight serial clocks later
module serial_led_shift_latch (
  input  wire logic       MCLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic       SCLK_I,
  input  wire logic       SDATA_I,
  input  wire logic       LATCH_LOAD_I,
  input  wire logic       BLANK_I,
  input  wire logic [7:0] OPEN_LOAD_I,
  output      logic       SDATA_O,
  output      logic [7:0] LED_SINK_O,
  output      logic [7:0] LED_SINK_OE_O
);

  typedef struct packed {
    logic       sclk_m;
    logic       sclk_s;
    logic       sclk_d;
    logic       sdat_m;
    logic       sdat_s;
    logic       load_m;
    logic       load_s;
    logic       load_d;
    logic       blank_m;
    logic       blank_s;
    logic [7:0] open_m;
    logic [7:0] open_s;
    logic       pend;
    logic [3:0] pend_ev;
    logic [7:0] shift;
    logic [7:0] latch;
    logic       transp;
    logic [3:0] settle;
    logic       sdout;
    logic [7:0] sink_oe;
    logic [7:0] sink_drv;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;
  logic       ev_ready;
  logic       ev_valid;
  logic [3:0] ev_word;
  logic       eng_ready;
  logic       pop;
  logic       fault_now;

  // engine does not drain events while the open-load sense settles
  assign eng_ready = (st_r.settle == led_latch_pkg::SETTLE_IDLE);
  assign pop       = ev_valid && eng_ready;

  // an output counts only when its latch bit asks for current and it is not blanked
  assign fault_now = |(st_r.open_s & st_r.latch & ~{led_latch_pkg::SHIFT_W{st_r.blank_s}});

  function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic din);
    shift_in = {cur[led_latch_pkg::OUT_BIT-1:0], din};
  endfunction

  event_fifo #(
    .WIDTH (led_latch_pkg::EV_W),
    .DEPTH (led_latch_pkg::BUF_DEPTH)
  ) u_events (
    .clk_i       (MCLK_I),
    .reset_n_i   (RESET_N_I),
    .in_valid_i  (st_r.pend),
    .in_ready_o  (ev_ready),
    .in_data_i   (st_r.pend_ev),
    .out_valid_o (ev_valid),
    .out_ready_i (eng_ready),
    .out_data_o  (ev_word)
  );

  always_comb begin
    logic       sclk_rise;
    logic       load_rise;
    logic       load_fall;
    logic [7:0] s;
    sclk_rise = 1'b0;
    load_rise = 1'b0;
    load_fall = 1'b0;
    s         = st_r.shift;
    st_nxt    = st_r;

    // two-stage synchronisers; edges are found only after the second stage
    st_nxt.sclk_m  = SCLK_I;
    st_nxt.sclk_s  = st_r.sclk_m;
    st_nxt.sclk_d  = st_r.sclk_s;
    st_nxt.sdat_m  = SDATA_I;
    st_nxt.sdat_s  = st_r.sdat_m;
    st_nxt.load_m  = LATCH_LOAD_I;
    st_nxt.load_s  = st_r.load_m;
    st_nxt.load_d  = st_r.load_s;
    st_nxt.blank_m = BLANK_I;
    st_nxt.blank_s = st_r.blank_m;
    st_nxt.open_m  = OPEN_LOAD_I;
    st_nxt.open_s  = st_r.open_m;

    sclk_rise = st_r.sclk_s && !st_r.sclk_d;
    load_rise = st_r.load_s && !st_r.load_d;
    load_fall = !st_r.load_s && st_r.load_d;

    // data is sampled at the same synchroniser depth as the clock, so
    // host hold time covers it
    // a waiting event stalls capture; events arriving meanwhile are lost,
    // which at the link rate cannot happen with a buffer this deep
    if (st_r.pend && ev_ready) begin
      st_nxt.pend = 1'b0;
    end
    if ((!st_r.pend || ev_ready) && (sclk_rise || load_rise || load_fall)) begin
      st_nxt.pend    = 1'b1;
      st_nxt.pend_ev = {sclk_rise, st_r.sdat_s, load_rise, load_fall};
    end

    // blanking enters the shift or latch path only through the fault status
    if (pop) begin
      if (ev_word[led_latch_pkg::EV_SHIFT]) begin
        s = shift_in(st_r.shift, ev_word[led_latch_pkg::EV_DATA]);
      end
      st_nxt.shift = s;
      if (ev_word[led_latch_pkg::EV_FALL]) begin
        st_nxt.latch  = s;
        st_nxt.transp = 1'b0;
      end else if (ev_word[led_latch_pkg::EV_RISE]) begin
        st_nxt.latch  = s;
        st_nxt.transp = 1'b1;
        st_nxt.settle = led_latch_pkg::SETTLE_CYC;
      end else if (st_r.transp) begin
        st_nxt.latch = s;
      end
    end else if (!eng_ready) begin
      st_nxt.settle = st_r.settle - 1'b1;
      if (st_r.settle == led_latch_pkg::SETTLE_ONE) begin
        // fault lands in D6 and D5 so the next word carries it out
        s[led_latch_pkg::FAULT_HI] = fault_now;
        s[led_latch_pkg::FAULT_LO] = fault_now;
        st_nxt.shift = s;
      end
      if (st_r.transp) begin
        st_nxt.latch = s;
      end
    end else if (st_r.transp) begin
      st_nxt.latch = st_r.shift;
    end

    // last stage drives the chain output: D7 first, then D6, D5, D4..D0
    st_nxt.sdout   = st_nxt.shift[led_latch_pkg::OUT_BIT];
    // sink enabled only for a set latch bit while not blanked
    st_nxt.sink_oe = st_r.blank_s ? led_latch_pkg::BYTE_ZERO : st_r.latch;
    // sinks only ever pull low; the enable decides whether current flows
    st_nxt.sink_drv = led_latch_pkg::BYTE_ZERO;
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign SDATA_O       = st_r.sdout;
  assign LED_SINK_OE_O = st_r.sink_oe;
  assign LED_SINK_O    = st_r.sink_drv;

  shift_enter_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    pop && ev_word[led_latch_pkg::EV_SHIFT]
    |=> st_r.shift[led_latch_pkg::IN_BIT] == $past(ev_word[led_latch_pkg::EV_DATA])
        && st_r.shift[7:1] == $past(st_r.shift[6:0]))
    else $error("shift register did not take the serial bit");

  shift_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    !pop && st_r.settle != led_latch_pkg::SETTLE_ONE |=> $stable(st_r.shift))
    else $error("shift register moved without a clock edge");

  chain_out_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    SDATA_O == st_r.shift[led_latch_pkg::OUT_BIT])
    else $error("serial output is not the last stage");

  latch_follow_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    st_r.transp && !pop && eng_ready |=> st_r.latch == $past(st_r.shift))
    else $error("transparent latch did not follow");

  latch_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    !st_r.transp && !pop |=> $stable(st_r.latch))
    else $error("closed latch changed");

  latch_capture_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    pop && ev_word[led_latch_pkg::EV_FALL] |=> !st_r.transp && st_r.latch == st_r.shift)
    else $error("latch did not capture on load fall");

  fault_write_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    st_r.settle == led_latch_pkg::SETTLE_ONE
    |=> st_r.shift[led_latch_pkg::FAULT_HI] == $past(fault_now)
        && st_r.shift[led_latch_pkg::FAULT_LO] == $past(fault_now)
        && st_r.shift[7] == $past(st_r.shift[7])
        && st_r.shift[4:0] == $past(st_r.shift[4:0]))
    else $error("fault bits written wrongly");

  fault_time_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    pop && ev_word[led_latch_pkg::EV_RISE] && !ev_word[led_latch_pkg::EV_FALL]
    |=> st_r.settle == led_latch_pkg::SETTLE_CYC ##12 st_r.settle == led_latch_pkg::SETTLE_ONE)
    else $error("fault status not sampled on time");

  blank_off_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    st_r.blank_s |=> LED_SINK_OE_O == led_latch_pkg::BYTE_ZERO)
    else $error("sink on while blanked");

  sink_follow_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    !st_r.blank_s |=> LED_SINK_OE_O == $past(st_r.latch))
    else $error("sink does not follow latch");

  // a waiting event that finds the buffer full stalls capture, so later events would be dropped without trace
  event_kept_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    st_r.pend |-> ev_ready)
    else $error("serial event found the buffer full");

  // the countdown is fixed, so the fault sample lands a set time after the rise
  settle_step_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    st_r.settle != led_latch_pkg::SETTLE_IDLE
    |=> st_r.settle == $past(st_r.settle) - led_latch_pkg::SETTLE_ONE)
    else $error("fault settle count skipped");

  latch_open_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    pop && ev_word[led_latch_pkg::EV_RISE] && !ev_word[led_latch_pkg::EV_FALL]
    |=> st_r.transp && st_r.latch == st_r.shift)
    else $error("latch did not open on load rise");

  fault_latch_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    st_r.transp && st_r.settle == led_latch_pkg::SETTLE_ONE |=> st_r.latch == st_r.shift)
    else $error("open latch missed the fault overwrite");

  // the fault write leaves D7 alone, so only a serial edge may move the chain output
  sdata_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    !(pop && ev_word[led_latch_pkg::EV_SHIFT])
    |=> $stable(SDATA_O))
    else $error("serial output moved without a serial edge");

  chain_shift_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    pop && ev_word[led_latch_pkg::EV_SHIFT] |=> SDATA_O == $past(st_r.shift[led_latch_pkg::OUT_BIT - 1]))
    else $error("chain output skipped a stage");

  blank_shift_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    $changed(st_r.blank_s) && !pop && st_r.settle != led_latch_pkg::SETTLE_ONE |=> $stable(st_r.shift))
    else $error("blanking disturbed the shift register");

  sink_drive_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    LED_SINK_O == led_latch_pkg::BYTE_ZERO)
    else $error("sink drive value not low");

endmodule // serial_led_shift_latch

// ---- verif/host_link_model.sv ----
`timescale 1ns/1ps

module host_link_model (
  input  wire logic mclk_i,
  input  wire logic chain_i,
  output      logic sclk_o,
  output      logic sdata_o,
  output      logic latch_load_o
);
  initial begin
    sclk_o       = 1'b0;
    sdata_o      = 1'b0;
    latch_load_o = 1'b0;
  end

  // one word at 64 ns per bit, MSB first; returns the bits that left the chain meanwhile
  task automatic xfer(input logic [7:0] w, output logic [7:0] back);
    for (int i = 7; i >= 0; i--) begin
      sclk_o  = 1'b0;
      sdata_o = w[i];
      repeat (4) @(negedge mclk_i);
      back[i] = chain_i;
      sclk_o  = 1'b1;
      repeat (4) @(negedge mclk_i);
    end
    sclk_o  = 1'b0;
    // clock parked low; data is stale now, so show the inverse rather than the last bit
    sdata_o = ~w[0];
  endtask

  // load takes the given level at once, without waiting for a word to be clocked in
  task automatic set_load(input logic v);
    latch_load_o = v;
  endtask
endmodule // host_link_model

// ---- verif/serial_led_shift_latch_tb_top.sv ----
`timescale 1ns/1ps

module serial_led_shift_latch_tb_top;
  logic       mclk = 1'b0;
  logic       reset_n, sclk, sdata_in, latch_load, blank, sdata_out, le_m;
  logic [7:0] open_load, sink, sink_oe, sr_m, lat_m;
  int         err_total, checks_done;
  int         cyc = 0;

  serial_led_shift_latch serial_led_shift_latch_inst (
    .MCLK_I(mclk), .RESET_N_I(reset_n), .SCLK_I(sclk), .SDATA_I(sdata_in),
    .LATCH_LOAD_I(latch_load), .BLANK_I(blank), .OPEN_LOAD_I(open_load),
    .SDATA_O(sdata_out), .LED_SINK_O(sink), .LED_SINK_OE_O(sink_oe));
  host_link_model host_link_model_inst (
    .mclk_i(mclk), .chain_i(sdata_out), .sclk_o(sclk), .sdata_o(sdata_in), .latch_load_o(latch_load));

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      finish_test();
    end
  end

  function automatic logic [7:0] exp_oe(input logic [7:0] lat, input logic blk);
    return blk ? 8'h00 : lat;
  endfunction

  // fault looks only at lit, unblanked outputs; the other six bits pass through
  function automatic logic [7:0] fault_in(input logic [7:0] s, input logic [7:0] open, input logic blk);
    logic f;
    f = |(open & s) & ~blk;
    return {s[7], f, f, s[4:0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic run_word(input logic [7:0] wd);
    logic [7:0] got;
    host_link_model_inst.xfer(wd, got);
    check(got, sr_m);
    sr_m = wd;
    if (le_m) lat_m = wd;
    repeat (4) @(negedge mclk);
    check({7'h00, sdata_out}, {7'h00, sr_m[7]});
    check(sink_oe, exp_oe(lat_m, blank));
  endtask

  task automatic load_cycle(input logic mid);
    host_link_model_inst.set_load(1'b1);
    le_m  = 1'b1;
    sr_m  = fault_in(sr_m, open_load, blank);
    // the transparent latch also shows the fault overwrite
    lat_m = sr_m;
    repeat (24) @(negedge mclk);
    check(sink_oe, exp_oe(lat_m, blank));
    check({7'h00, sdata_out}, {7'h00, sr_m[7]});
    if (mid) begin
      run_word(8'($urandom));
      check(sink_oe, exp_oe(lat_m, blank));
    end
    host_link_model_inst.set_load(1'b0);
    le_m  = 1'b0;
    blank = ~blank;
    repeat (8) @(negedge mclk);
    check(sink_oe, exp_oe(lat_m, blank));
    check(sink, 8'h00);
  endtask

  // a word right behind the load rise: its first edges wait in the buffer while the fault settles
  task automatic burst_word(input logic [7:0] wd);
    logic [7:0] got;
    host_link_model_inst.set_load(1'b1);
    le_m = 1'b1;
    sr_m = fault_in(sr_m, open_load, blank);
    host_link_model_inst.xfer(wd, got);
    // the second bit leaves while the first edge is still held back, so it is not compared
    check({got[7], 1'b0, got[5:0]}, {sr_m[7], 1'b0, sr_m[5:0]});
    sr_m  = wd;
    lat_m = wd;
    repeat (4) @(negedge mclk);
    check({7'h00, sdata_out}, {7'h00, sr_m[7]});
    check(sink_oe, exp_oe(lat_m, blank));
    check(sink, 8'h00);
    host_link_model_inst.set_load(1'b0);
    le_m  = 1'b0;
    blank = ~blank;
    repeat (8) @(negedge mclk);
    check(sink_oe, exp_oe(lat_m, blank));
    blank = ~blank;
    repeat (8) @(negedge mclk);
    check(sink_oe, exp_oe(lat_m, blank));
  endtask

  initial begin
    reset_n     = 1'b0;
    blank       = 1'b0;
    open_load   = 8'h00;
    sr_m        = 8'h00;
    lat_m       = 8'h00;
    le_m        = 1'b0;
    err_total   = 0;
    checks_done = 0;
    void'($urandom(32'hc649_bc92));
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    check({7'h00, sdata_out}, 8'h00);
    check(sink_oe, 8'h00);
    for (int k = 0; k < 14; k++) begin
      blank     = (k > 2) ? 1'($urandom) : 1'b0;
      open_load = (k == 0) ? 8'h01 : 8'($urandom);
      run_word((k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom));
      load_cycle(k == 5 || k == 9);
    end
    for (int k = 0; k < 4; k++) begin
      blank     = 1'($urandom);
      open_load = 8'($urandom);
      burst_word(8'($urandom));
    end
    finish_test();
  end
endmodule // serial_led_shift_latch_tb_top
